// >>> mcpt_pkg.sv
// Shared constants and state layout for the match/clear compare PWM timer
package mcpt_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int AW    = 8;
  localparam int DW    = 16;
  localparam int N_CH  = 4;
  localparam int N_CTR = 2;

  // ---------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [AW-1:0] OFS_CHCFG   = 8'h04;
  localparam logic [AW-1:0] OFS_LIMIT_A = 8'h08;
  localparam logic [AW-1:0] OFS_LIMIT_B = 8'h0C;
  localparam logic [AW-1:0] OFS_CMP0    = 8'h10;  // Channel m at OFS_CMP0 + 4*m
  localparam logic [AW-1:0] OFS_FLAGS   = 8'h20;
  localparam logic [AW-1:0] OFS_CNT_A   = 8'h24;
  localparam logic [AW-1:0] OFS_CNT_B   = 8'h28;
  localparam logic [AW-1:0] OFS_EDGE    = 8'h2C;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_POWER   = 0;
  localparam int CTRL_RUN     = 1;   // Two bits, counter a then b
  localparam int CTRL_CLR     = 3;   // Two strobe bits, read as zero
  localparam int CTRL_MODE    = 5;   // Two bits, 1 = match-and-clear
  localparam int CTRL_STAGGER = 7;
  localparam int CTRL_PSC_A   = 8;   // Three bits
  localparam int CTRL_PSC_B   = 12;  // Three bits
  localparam int CFG_CCSEL    = 0;   // Four bits, 1 = compare
  localparam int CFG_CSEL     = 4;   // Four bits, 1 = counter b
  localparam int CFG_ALV      = 8;   // Four bits, 1 = active high
  localparam int CFG_GATE     = 12;  // Four bits, 1 = output enabled

  // ---------------------------------------------------------------------------
  // Reset values and special values
  // ---------------------------------------------------------------------------
  localparam logic [DW-1:0]   RST_LIMIT  = 16'hFFFF;
  localparam logic [N_CH-1:0] RST_ALV    = 4'hF;
  localparam logic [DW-1:0]   LIMIT_FREE = 16'hFFFF;

  // ---------------------------------------------------------------------------
  // Timing counts in system clocks
  // ---------------------------------------------------------------------------
  localparam logic [3:0] START_EARLY = 4'hE;  // 14 clocks
  localparam logic [3:0] START_LATE  = 4'h8;  // 8 clocks
  localparam logic [2:0] RELOAD_DLY  = 3'h5;  // 5 clocks

  // ---------------------------------------------------------------------------
  // Whole state of the timer
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [N_CTR-1:0][DW-1:0] cnt;
    logic [N_CTR-1:0][7:0]    div;
    logic [N_CTR-1:0][3:0]    start;
    logic [N_CTR-1:0]         started;
    logic                     power;
    logic [N_CTR-1:0]         run;
    logic [N_CTR-1:0]         mode;
    logic                     stagger;
    logic [N_CTR-1:0][2:0]    psc;
    logic [N_CH-1:0]          ccsel;
    logic [N_CH-1:0]          csel;
    logic [N_CH-1:0]          alv;
    logic [N_CH-1:0]          gate;
    logic [N_CH-1:0][1:0]     edge_sel;
    logic [N_CTR-1:0][DW-1:0] lim;
    logic [N_CH-1:0][DW-1:0]  master;
    logic [N_CH-1:0][DW-1:0]  slave;
    logic [N_CH-1:0][2:0]     ld;
    logic [N_CH-1:0]          hold_pe;
    logic [N_CH-1:0]          smp;
    logic [N_CH-1:0]          lvl;
    logic [N_CH-1:0]          capt;
    logic [N_CH-1:0]          pend;
    logic [N_CH-1:0]          ovf;
    logic [N_CH-1:0]          act;
    logic [N_CH-1:0][2:0]     pipe;
    logic [N_CH-1:0]          sync1;
    logic [N_CH-1:0]          sync2;
    logic [N_CH-1:0]          ch_irq;
    logic [N_CTR-1:0]         lim_irq;
    logic [N_CTR-1:0]         ovf_irq;
    logic [N_CH-1:0]          pulse;
    logic [DW-1:0]            rdata;
  } mcpt_state_t;

endpackage

// >>> mcpt_timer.sv
// Two-counter compare/capture timer with match-and-clear and PWM outputs
`timescale 1ns/10ps

module mcpt_timer (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RSTN,
  // Register port
  input  wire logic [mcpt_pkg::AW-1:0]      ADDR,
  input  wire logic [mcpt_pkg::DW-1:0]      WDATA,
  input  wire logic                         WR,
  input  wire logic                         RD,
  output logic      [mcpt_pkg::DW-1:0]      RDATA,
  // Capture pins
  input  wire logic [mcpt_pkg::N_CH-1:0]    CAP_IN,
  // Interrupt requests
  output logic      [mcpt_pkg::N_CH-1:0]    CH_IRQ,
  output logic      [mcpt_pkg::N_CTR-1:0]   LIM_IRQ,
  output logic      [mcpt_pkg::N_CTR-1:0]   OVF_IRQ,
  // Pulse outputs
  output logic      [mcpt_pkg::N_CH-1:0]    PULSE_OUT
);

  mcpt_pkg::mcpt_state_t s_q;
  mcpt_pkg::mcpt_state_t s_d;

  logic [mcpt_pkg::N_CTR-1:0] tick;
  logic [mcpt_pkg::N_CTR-1:0] lim_ev;
  logic [mcpt_pkg::N_CTR-1:0] ovf_ev;
  logic [mcpt_pkg::N_CTR-1:0] pe;
  logic [mcpt_pkg::N_CH-1:0]  match;
  logic [mcpt_pkg::N_CH-1:0]  cap_ev;
  logic [7:0]                 mask;
  logic                       en_old;
  logic                       en_new;
  logic                       c;
  logic                       addr_hit;
  logic                       rd_hit;
  logic                       pwm;
  logic [mcpt_pkg::DW-1:0]    eff;
  logic [3:0]                 stage;
  logic                       raw;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // All behaviour is computed here from the registered state
  always_comb begin
    s_d      = s_q;
    tick     = '0;
    lim_ev   = '0;
    ovf_ev   = '0;
    pe       = '0;
    match    = '0;
    cap_ev   = '0;
    mask     = '0;
    en_old   = 1'b0;
    en_new   = 1'b0;
    c        = 1'b0;
    addr_hit = 1'b0;
    rd_hit   = 1'b0;
    pwm      = 1'b0;
    eff      = '0;
    stage    = '0;
    raw      = 1'b0;

    // Two-flop synchronisers for the capture pins
    s_d.sync1 = CAP_IN;
    s_d.sync2 = s_q.sync1;

    // Configuration writes
    if (WR) begin
      case (ADDR)
        mcpt_pkg::OFS_CTRL: begin
          s_d.power   = WDATA[mcpt_pkg::CTRL_POWER];
          s_d.run     = WDATA[mcpt_pkg::CTRL_RUN +: 2];
          s_d.mode    = WDATA[mcpt_pkg::CTRL_MODE +: 2];
          s_d.stagger = WDATA[mcpt_pkg::CTRL_STAGGER];
          s_d.psc[0]  = WDATA[mcpt_pkg::CTRL_PSC_A +: 3];
          s_d.psc[1]  = WDATA[mcpt_pkg::CTRL_PSC_B +: 3];
        end
        mcpt_pkg::OFS_CHCFG: begin
          s_d.ccsel = WDATA[mcpt_pkg::CFG_CCSEL +: 4];
          s_d.csel  = WDATA[mcpt_pkg::CFG_CSEL +: 4];
          s_d.alv   = WDATA[mcpt_pkg::CFG_ALV +: 4];
          s_d.gate  = WDATA[mcpt_pkg::CFG_GATE +: 4];
        end
        mcpt_pkg::OFS_EDGE:    s_d.edge_sel = WDATA[7:0];
        mcpt_pkg::OFS_LIMIT_A: s_d.lim[0] = WDATA;
        mcpt_pkg::OFS_LIMIT_B: s_d.lim[1] = WDATA;
        default: ;
      endcase
    end

    // Counters: start delay, prescaler, limit compare
    for (int i = 0; i < mcpt_pkg::N_CTR; i++) begin
      en_old     = s_q.power & s_q.run[i];
      en_new     = s_d.power & s_d.run[i];
      mask       = 8'((9'h002 << s_q.psc[i]) - 9'h001);
      s_d.div[i] = s_q.power ? s_q.div[i] + 8'h01 : 8'h00;
      tick[i]    = s_q.started[i] && ((s_q.div[i] & mask) == mask);
      if (!en_new) begin
        s_d.start[i]   = 4'h0;
        s_d.started[i] = 1'b0;
      end else if (!en_old) begin
        s_d.start[i] = s_q.power ? mcpt_pkg::START_LATE : mcpt_pkg::START_EARLY;
      end else if (s_q.start[i] != 4'h0) begin
        s_d.start[i] = s_q.start[i] - 4'h1;
        if (s_q.start[i] == 4'h1) begin
          s_d.started[i] = 1'b1;
        end
      end
      if (WR && ADDR == mcpt_pkg::OFS_CTRL && WDATA[mcpt_pkg::CTRL_CLR + i]) begin
        s_d.cnt[i] = '0;
      end else if (tick[i]) begin
        // An all-ones limit never clears, so the counter wraps as in free run
        if (s_q.mode[i] && s_q.lim[i] != mcpt_pkg::LIMIT_FREE &&
            s_q.cnt[i] == s_q.lim[i]) begin
          s_d.cnt[i] = '0;
          lim_ev[i]  = 1'b1;
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
          ovf_ev[i]  = (s_q.cnt[i] == 16'hFFFF);
        end
      end
      pe[i] = lim_ev[i] | ovf_ev[i];
      // A zero limit holds the request high for as long as the counter runs
      s_d.lim_irq[i] = lim_ev[i] |
                       (s_q.started[i] && s_q.mode[i] && s_q.lim[i] == 16'h0000);
      s_d.ovf_irq[i] = ovf_ev[i];
    end

    // Channels: compare, reload, capture, pulse
    s_d.rdata = '0;
    for (int m = 0; m < mcpt_pkg::N_CH; m++) begin
      c        = s_q.csel[m];
      addr_hit = (ADDR == 8'(mcpt_pkg::OFS_CMP0 + 8'(4 * m)));
      rd_hit   = RD && addr_hit;
      pwm      = s_q.ccsel[m] & s_q.gate[m];
      // A zero compare value is matched when the counter reaches one
      eff      = (s_q.slave[m] == '0) ? 16'h0001 : s_q.slave[m];
      match[m] = s_q.ccsel[m] && tick[c] && s_d.cnt[c] == eff &&
                 !(s_q.mode[c] && s_q.slave[m] > s_q.lim[c]);

      // In PWM the slave waits for the period end so a pulse is never cut short
      if (s_q.hold_pe[m] && pe[c]) begin
        s_d.slave[m]   = s_q.master[m];
        s_d.hold_pe[m] = 1'b0;
      end
      if (WR && addr_hit && s_q.ccsel[m]) begin
        s_d.master[m] = WDATA;
        if (pwm && s_q.started[c]) begin
          s_d.hold_pe[m] = 1'b1;
          s_d.ld[m]      = 3'h0;
        end else begin
          s_d.hold_pe[m] = 1'b0;
          s_d.ld[m]      = mcpt_pkg::RELOAD_DLY;
        end
      end else if (s_q.ld[m] != 3'h0) begin
        s_d.ld[m] = s_q.ld[m] - 3'h1;
        if (s_q.ld[m] == 3'h1) begin
          s_d.slave[m] = s_q.master[m];
        end
      end

      // Input filter sampled on count ticks: two equal samples make an edge
      if (tick[c]) begin
        s_d.smp[m] = s_q.sync2[m];
        if (s_q.sync2[m] == s_q.smp[m] && s_q.sync2[m] != s_q.lvl[m]) begin
          s_d.lvl[m]  = s_q.sync2[m];
          s_d.capt[m] = s_q.sync2[m] ? s_q.edge_sel[m][0] : s_q.edge_sel[m][1];
        end else if (s_q.capt[m]) begin
          s_d.capt[m] = 1'b0;
          // A read of the same register blocks the capture, the edge is lost
          if (!s_q.ccsel[m] && !rd_hit) begin
            cap_ev[m]    = 1'b1;
            s_d.slave[m] = s_q.cnt[c];
          end
        end
      end

      // Overflow since last capture; a new overflow wins over the clear
      s_d.pend[m] = (s_q.pend[m] & ~cap_ev[m]) | pe[c];
      if (rd_hit && !s_q.ccsel[m]) begin
        s_d.ovf[m] = s_q.pend[m];
      end
      s_d.ch_irq[m] = match[m] | cap_ev[m];

      // Pulse state: set at each period end, cleared at the compare match
      if (!s_q.power || !s_q.started[c]) begin
        s_d.act[m] = 1'b0;
      end else if (match[m]) begin
        s_d.act[m] = 1'b0;
      end else if (pe[c] && pwm) begin
        s_d.act[m] = 1'b1;
      end
      if (s_d.slave[m] == '0) begin
        s_d.act[m] = 1'b0;
      end

      // Staggering delays channel m by m clocks to spread switching current
      s_d.pipe[m]   = {s_q.pipe[m][1:0], s_q.act[m] & s_q.gate[m]};
      stage         = {s_q.pipe[m], s_q.act[m] & s_q.gate[m]};
      raw           = s_q.stagger ? stage[m] : stage[0];
      s_d.pulse[m]  = (s_q.power && raw) ? s_q.alv[m] : ~s_q.alv[m];

      if (rd_hit) begin
        s_d.rdata = s_q.slave[m];
      end
    end

    // Read data, valid in the cycle after the strobe only
    if (RD) begin
      case (ADDR)
        mcpt_pkg::OFS_CTRL: begin
          s_d.rdata[mcpt_pkg::CTRL_POWER]      = s_q.power;
          s_d.rdata[mcpt_pkg::CTRL_RUN +: 2]   = s_q.run;
          s_d.rdata[mcpt_pkg::CTRL_MODE +: 2]  = s_q.mode; // Clear strobes read 0
          s_d.rdata[mcpt_pkg::CTRL_STAGGER]    = s_q.stagger;
          s_d.rdata[mcpt_pkg::CTRL_PSC_A +: 3] = s_q.psc[0];
          s_d.rdata[mcpt_pkg::CTRL_PSC_B +: 3] = s_q.psc[1];
        end
        mcpt_pkg::OFS_CHCFG:   s_d.rdata = {s_q.gate, s_q.alv, s_q.csel, s_q.ccsel};
        mcpt_pkg::OFS_EDGE:    s_d.rdata = {8'h00, s_q.edge_sel};
        mcpt_pkg::OFS_LIMIT_A: s_d.rdata = s_q.lim[0];
        mcpt_pkg::OFS_LIMIT_B: s_d.rdata = s_q.lim[1];
        mcpt_pkg::OFS_FLAGS:   s_d.rdata = {12'h000, s_q.ovf};
        mcpt_pkg::OFS_CNT_A:   s_d.rdata = s_q.cnt[0];
        mcpt_pkg::OFS_CNT_B:   s_d.rdata = s_q.cnt[1];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // Constant reset; active-high outputs default so pulses start at 0
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q     <= '0;
      s_q.lim <= {mcpt_pkg::RST_LIMIT, mcpt_pkg::RST_LIMIT};
      s_q.alv <= mcpt_pkg::RST_ALV;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign RDATA     = s_q.rdata;
  assign CH_IRQ    = s_q.ch_irq;
  assign LIM_IRQ   = s_q.lim_irq;
  assign OVF_IRQ   = s_q.ovf_irq;
  assign PULSE_OUT = s_q.pulse;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  property p_match_value;
    s_q.ccsel[0] && !s_q.csel[0] && s_q.ch_irq[0] && $past(s_q.slave[0]) != '0
      |-> s_q.cnt[0] == $past(s_q.slave[0]);
  endproperty
  a_match_value: assert property (p_match_value)
    else $error("Compare irq without counter match");

  property p_lim_clear;
    s_q.mode[0] && s_q.lim_irq[0] && s_q.lim[0] != '0 |-> s_q.cnt[0] == '0;
  endproperty
  a_lim_clear: assert property (p_lim_clear)
    else $error("Limit irq without counter clear");

  property p_lim_zero;
    s_q.started[0] && s_q.mode[0] && s_q.lim[0] == '0 && s_q.cnt[0] == '0
      |=> s_q.lim_irq[0] && s_q.cnt[0] == '0;
  endproperty
  a_lim_zero: assert property (p_lim_zero)
    else $error("Zero limit did not hold counter and irq");

  property p_lim_full;
    s_q.mode[0] && s_q.lim[0] == 16'hFFFF |=> !s_q.lim_irq[0];
  endproperty
  a_lim_full: assert property (p_lim_full)
    else $error("Limit irq fired with all-ones limit");

  property p_zero_cmp;
    s_q.ccsel[0] && !s_q.csel[0] && s_q.ch_irq[0] && $past(s_q.slave[0]) == '0
      |-> s_q.cnt[0] == 16'h0001;
  endproperty
  a_zero_cmp: assert property (p_zero_cmp)
    else $error("Zero compare matched away from one");

  property p_above_limit;
    s_q.mode[0] && s_q.ccsel[0] && !s_q.csel[0] && s_q.slave[0] > s_q.lim[0]
      |=> !s_q.ch_irq[0];
  endproperty
  a_above_limit: assert property (p_above_limit)
    else $error("Compare above limit produced irq");

  property p_reload5;
    s_q.ld[0] == mcpt_pkg::RELOAD_DLY |-> ##5 s_q.slave[0] == s_q.master[0];
  endproperty
  a_reload5: assert property (p_reload5)
    else $error("Slave not loaded five clocks after write");

  property p_pwm_off;
    s_q.ccsel[0] && s_q.gate[0] && s_q.ch_irq[0] |-> !s_q.act[0];
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("Pulse still active after compare match");

  property p_zero_inactive;
    s_q.slave[0] == '0 |-> !s_q.act[0];
  endproperty
  a_zero_inactive: assert property (p_zero_inactive)
    else $error("Zero compare left pulse active");

  property p_power_off;
    !s_q.power |=> s_q.pulse == ~$past(s_q.alv);
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("Pulse not inactive with power off");

  property p_clr_read;
    $past(RD && ADDR == mcpt_pkg::OFS_CTRL) |-> s_q.rdata[mcpt_pkg::CTRL_CLR +: 2] == 2'b00;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("Clear strobe read back non-zero");

  property p_ovf_read;
    $past(RD && ADDR == (mcpt_pkg::OFS_CMP0 + 8'h04) && !s_q.ccsel[1])
      |-> s_q.ovf[1] == $past(s_q.pend[1]);
  endproperty
  a_ovf_read: assert property (p_ovf_read)
    else $error("Overflow flag not refreshed on capture read");

  property p_start_late;
    $rose(s_q.power & s_q.run[0]) && $past(s_q.power)
      |-> ##8 (s_q.started[0] && !$past(s_q.started[0]));
  endproperty
  a_start_late: assert property (p_start_late)
    else $error("Late start not eight clocks");

  property p_start_early;
    $rose(s_q.power & s_q.run[0]) && !$past(s_q.power)
      |-> ##14 (s_q.started[0] && !$past(s_q.started[0]));
  endproperty
  a_start_early: assert property (p_start_early)
    else $error("Early start not fourteen clocks");

  c_pwm_toggle:  cover property ($fell(s_q.act[0]) ##[1:1000] $rose(s_q.act[0]));
  c_lim_match:   cover property (s_q.lim_irq[0] && s_q.lim[0] != '0);
  c_capture:     cover property (s_q.ch_irq[1] && !s_q.ccsel[1]);
  c_pwm_reload:  cover property (s_q.hold_pe[0] ##[1:1000] !s_q.hold_pe[0]);

endmodule

// >>> mcpt_pin_drv.sv
// Behavioural source for the capture pins of the timer
`timescale 1ns/10ps

module mcpt_pin_drv (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Command from the bench
  input  wire logic       go,
  input  wire logic [1:0] ch,
  input  wire logic [7:0] width,
  // Pin levels
  output logic      [3:0] cap
);
  logic [7:0] left_q;
  logic [1:0] ch_q;

  // ---------------------------------------------------------------------------
  // Pulse generator
  // ---------------------------------------------------------------------------
  // One high pulse of an exact width in system clocks; pins rest low between pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap    <= 4'h0;
      left_q <= 8'h00;
      ch_q   <= 2'h0;
    end else if (go) begin
      cap[ch] <= 1'b1;
      left_q  <= width;
      ch_q    <= ch;
    end else if (left_q == 8'h01) begin
      cap[ch_q] <= 1'b0;
      left_q    <= 8'h00;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench for the match/clear compare PWM timer
`timescale 1ns/10ps

module tb;
  logic                        CLK = 1'b0;
  logic                        RSTN = 1'b0;
  logic [mcpt_pkg::AW-1:0]     ADDR = 8'h00;
  logic [mcpt_pkg::DW-1:0]     WDATA = 16'h0000;
  logic                        WR = 1'b0;
  logic                        RD = 1'b0;
  logic [mcpt_pkg::DW-1:0]     RDATA;
  logic [mcpt_pkg::N_CH-1:0]   CAP_IN;
  logic [mcpt_pkg::N_CH-1:0]   CH_IRQ;
  logic [mcpt_pkg::N_CTR-1:0]  LIM_IRQ;
  logic [mcpt_pkg::N_CTR-1:0]  OVF_IRQ;
  logic [mcpt_pkg::N_CH-1:0]   PULSE_OUT;
  logic                        go = 1'b0;
  logic [1:0]                  go_ch = 2'h0;
  logic [7:0]                  go_w = 8'h00;
  int                          err_count = 0;
  int                          compares = 0;
  logic [15:0]                 rv;

  // ---------------------------------------------------------------------------
  // Clock, design and pin source
  // ---------------------------------------------------------------------------
  // 250 MHz system clock
  always #2 CLK = ~CLK;

  mcpt_timer i_mcpt_timer (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CAP_IN(CAP_IN), .CH_IRQ(CH_IRQ), .LIM_IRQ(LIM_IRQ),
    .OVF_IRQ(OVF_IRQ), .PULSE_OUT(PULSE_OUT));

  mcpt_pin_drv i_mcpt_pin_drv (.clk(CLK), .rst_n(RSTN), .go(go), .ch(go_ch), .width(go_w),
    .cap(CAP_IN));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask

  // Bounded wait for a limit match pulse; running out ends the run
  task automatic wait_lim();
    for (int i = 0; i < 400; i++) begin
      @(posedge CLK);
      #1;
      if (LIM_IRQ[0] === 1'b1) return;
    end
    err_count++;
    $display("ERROR limit match wait expected pulse seen none");
    give_verdict();
  endtask

  // Power off, configure channel 0 on counter a, limit 0010, then power and run in clear mode
  task automatic setup(input logic [15:0] cfg, input logic [15:0] cmp);
    wr(mcpt_pkg::OFS_CTRL, 16'h0000);
    wr(mcpt_pkg::OFS_CHCFG, cfg);
    wr(mcpt_pkg::OFS_LIMIT_A, 16'h0010);
    wr(mcpt_pkg::OFS_EDGE, 16'h0004);
    wr(mcpt_pkg::OFS_CMP0, cmp);
    repeat (8) @(posedge CLK);
    wr(mcpt_pkg::OFS_CTRL, 16'h0023);
  endtask

  // One whole period between limit matches: pulse active cycles and match pulses
  task automatic period(output int len, output int hi, output int irq);
    wait_lim();
    len = 1;
    hi  = PULSE_OUT[0];
    irq = CH_IRQ[0];
    for (int i = 0; i < 200; i++) begin
      @(posedge CLK);
      #1;
      if (LIM_IRQ[0] === 1'b1) break;
      len++;
      hi  += PULSE_OUT[0];
      irq += CH_IRQ[0];
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset values, unmapped read, clear strobe and limit period
  task automatic t_basic();
    int len;
    int hi;
    int irq;
    rd(mcpt_pkg::OFS_LIMIT_A, rv);
    check("limit_a reset", rv, mcpt_pkg::RST_LIMIT);
    rd(8'hF0, rv);
    check("unmapped read", rv, 16'h0000);
    setup(16'h0F01, 16'h0005);
    rd(mcpt_pkg::OFS_CNT_A, rv);
    check("count before start", rv, 16'h0000);
    check("pulse before first match", PULSE_OUT[0], 1'b0);
    period(len, hi, irq);
    check("limit period clocks", len, 34);
    check("compare irqs per period", irq, 1);
    check("no overflow irq in clear mode", OVF_IRQ, 2'b00);
    wr(mcpt_pkg::OFS_CTRL, 16'h002B);
    rd(mcpt_pkg::OFS_CTRL, rv);
    check("clear strobe reads zero", rv, 16'h0023);
    rd(mcpt_pkg::OFS_CNT_A, rv);
    check("count after clear", rv < 16'h0003, 1'b1);
    // Run raised while already powered takes the short start path
    wr(mcpt_pkg::OFS_CTRL, 16'h0029);
    wr(mcpt_pkg::OFS_CTRL, 16'h0023);
    rd(mcpt_pkg::OFS_CNT_A, rv);
    check("count before late start", rv, 16'h0000);
    repeat (10) @(posedge CLK);
    rd(mcpt_pkg::OFS_CNT_A, rv);
    check("count after late start", rv >= 16'h0002 && rv <= 16'h0003, 1'b1);
  endtask

  // PWM width and match pulses for compare zero, inside, equal and above the limit
  task automatic t_pwm();
    logic [15:0] cmp_t [4] = '{16'h0000, 16'h0005, 16'h0010, 16'h0020};
    int          hi_t  [4] = '{0, 10, 32, 34};
    int          irq_t [4] = '{1, 1, 1, 0};
    int          len;
    int          hi;
    int          irq;
    for (int k = 0; k < 4; k++) begin
      setup(16'hFF01, cmp_t[k]);
      #1 check("pwm idle before limit", PULSE_OUT[0], 1'b0);
      wait_lim();
      period(len, hi, irq);
      check("pwm active clocks", hi, hi_t[k]);
      check("pwm match irqs", irq, irq_t[k]);
    end
  endtask

  // Compare rewrite while running waits for the next limit match, then power off
  task automatic t_reload();
    int len;
    int hi;
    int irq;
    setup(16'hFF01, 16'h0005);
    wait_lim();
    wait_lim();
    wr(mcpt_pkg::OFS_CMP0, 16'h0008);
    rd(mcpt_pkg::OFS_CMP0, rv);
    check("slave before reload", rv, 16'h0005);
    period(len, hi, irq);
    check("pwm width after reload", hi, 16);
    wait_lim();
    wr(mcpt_pkg::OFS_CTRL, 16'h0000);
    repeat (3) @(posedge CLK);
    #1 check("pulse with power off", PULSE_OUT[0], 1'b0);
  endtask

  // Capture filter: a one-tick pulse is dropped, a two-tick pulse is captured
  task automatic t_capture();
    int seen;
    int lat;
    setup(16'h0F01, 16'h0005);
    rd(mcpt_pkg::OFS_FLAGS, rv);
    check("overflow flag before read", rv, 16'h0000);
    repeat (20) @(posedge CLK);
    for (int w = 0; w < 2; w++) begin
      seen = 0;
      lat  = -1;
      @(posedge CLK);
      go_ch <= 2'h1;
      go_w  <= (w == 0) ? 8'h02 : 8'h04;
      go    <= 1'b1;
      @(posedge CLK);
      go <= 1'b0;
      for (int i = 0; i < 30; i++) begin
        @(posedge CLK);
        #1 seen += CH_IRQ[1];
        if (CH_IRQ[1] === 1'b1 && lat < 0) lat = i;
      end
      check("capture irqs", seen, w);
      if (w == 1) check("capture delay", lat >= 5 && lat <= 7, 1'b1);
    end
    // A period end after the capture shows up only once the channel is read
    wait_lim();
    rd(mcpt_pkg::OFS_CMP0 + 8'h04, rv);
    check("captured count in range", rv <= 16'h0010, 1'b1);
    rd(mcpt_pkg::OFS_FLAGS, rv);
    check("overflow flag after read", rv, 16'h0002);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    t_basic();
    t_pwm();
    t_reload();
    t_capture();
    give_verdict();
  end
endmodule
